// [shared/fulg_regs.svh]
// register offsets, field positions and reset values of the link guard
`ifndef FULG_REGS_SVH
`define FULG_REGS_SVH

// global registers (byte addresses)
`define FULG_GCTRL 12'h000
`define FULG_IRQ_STAT 12'h004
`define FULG_IRQ_MASK 12'h008
// per-unit windows start here, one 32-byte window per unit
`define FULG_UNIT_BASE_IDX 7'h08
`define FULG_UNIT_SHIFT 5
// per-unit register offsets inside a window
`define FULG_CFG 5'h00
`define FULG_SER0 5'h04
`define FULG_SER1 5'h08
`define FULG_SER2 5'h0c
`define FULG_FSAFE 5'h10
`define FULG_STAT 5'h14
// field positions
`define FULG_GCTRL_TEST 0
`define FULG_CFG_EN 0
`define FULG_CFG_VAR_LSB 1
`define FULG_CFG_CORE_LSB 3
`define FULG_STAT_ONLINE 3
`define FULG_STAT_RVAR_LSB 4
`define FULG_STAT_RCORE_LSB 6
`define FULG_STAT_LABEL_LSB 16
// reset values and the accepted core range
`define FULG_EN_RST 1'b0
`define FULG_VAR_RST 2'h0
`define FULG_CORE_RST 3'h1
`define FULG_SER_RST 96'h0
`define FULG_CORE_MIN 3'h1
`define FULG_CORE_MAX 3'h4
// variant codes
`define FULG_VAR_CC5 2'h0
`define FULG_VAR_CV5 2'h1
`define FULG_VAR_CC1 2'h2
`define FULG_VAR_CV1 2'h3
// slot letters of the two process cards and the port digit base (ascii)
`define FULG_SLOT0 8'h46
`define FULG_SLOT1 8'h4a
`define FULG_DIGIT0 8'h30

`endif

// [shared/fulg_pkg.sv]
// types shared by the field unit link guard
package fulg_pkg;

    // per-unit guard state, read back as its position in this list
    typedef enum logic [2:0] {
        st_disabled,
        st_comm_lost,
        st_mismatch,
        st_trouble,
        st_ok
    } fulg_state_e;

    // how one analogue bank is interpreted
    typedef enum logic [1:0] {
        bank_cur_5a,
        bank_cur_1a,
        bank_volt
    } fulg_bank_e;

    // interpretation of both analogue banks of one remote unit
    typedef struct packed {
        fulg_bank_e bank0;
        fulg_bank_e bank1;
    } fulg_banks_s;

    // one status report from a remote unit
    typedef struct packed {
        logic valid;
        logic [95:0] serial;
        logic [1:0] variant;
        logic [2:0] core;
        logic trouble;
    } fulg_rpt_s;

endpackage : fulg_pkg

// [rtl/fulg_top.sv]
// field unit link guards for all optical ports, with ahb-lite registers
`timescale 1ns/1ps
`include "fulg_regs.svh"

module fulg_top
    import fulg_pkg::*;
#(
    parameter int CARDS = 2,
    parameter int PORTS = 8,
    parameter int DATA_W = 16,
    parameter int CMD_W = 8
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // interrupt
    output logic irq,
    // remote side, one entry per unit
    input wire fulg_rpt_s rpt [CARDS*PORTS],
    input wire logic link_up [CARDS*PORTS],
    input wire logic [DATA_W-1:0] rx_data [CARDS*PORTS],
    output logic [CMD_W-1:0] cmd_out [CARDS*PORTS],
    // protection side, one entry per unit
    input wire logic [CMD_W-1:0] cmd_req [CARDS*PORTS],
    output logic [DATA_W-1:0] data_out [CARDS*PORTS],
    output logic online [CARDS*PORTS],
    output fulg_banks_s banks [CARDS*PORTS]
);

    localparam int UNITS = CARDS * PORTS;

    // the label and address maps only cover two cards of eight ports
    // eight per card
    if (PORTS != 8 || CARDS < 1 || CARDS > 2 || DATA_W > 32
        || CMD_W < 1) begin : g_bad_cfg
        $error("fulg_top: unsupported CARDS, PORTS, DATA_W or CMD_W");
    end

    // unit index of a per-unit window, all ones below the first window
    function automatic logic [6:0] unit_of(input logic [11:0] a);
        logic [6:0] idx;
        idx = a[11:`FULG_UNIT_SHIFT] - `FULG_UNIT_BASE_IDX;
        if (a[11:`FULG_UNIT_SHIFT] < `FULG_UNIT_BASE_IDX) begin
            idx = 7'h7f;
        end
        return idx;
    endfunction : unit_of

    // ascii label: slot letter then port digit
    // slot plus port
    function automatic logic [15:0] label_of(input int u);
        logic [7:0] slot;
        logic [7:0] digit;
        slot = (u / 8 == 0) ? `FULG_SLOT0 : `FULG_SLOT1;
        digit = `FULG_DIGIT0 + 8'((u % 8) + 1);
        return {slot, digit};
    endfunction : label_of

    // ahb address phase capture
    logic wr_pend;
    logic [11:0] wr_addr;
    logic addr_phase;
    assign addr_phase = hsel && hready && htrans[1];

    // zero wait states; every access answers okay
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // remember a write so its data phase can be applied
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_pend <= 1'b0;
            wr_addr <= 12'h0;
        end else begin
            wr_pend <= addr_phase && hwrite;
            if (addr_phase) begin
                wr_addr <= haddr[11:0];
            end
        end
    end

    // global registers
    logic test_mode;
    logic [UNITS-1:0] irq_stat;
    logic [UNITS-1:0] irq_mask;
    logic [UNITS-1:0] alarm_evt;

    // test-forcible mode and interrupt mask
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            test_mode <= 1'b0;
            irq_mask <= '0;
        end else if (wr_pend) begin
            if (wr_addr == `FULG_GCTRL) begin
                test_mode <= hwdata[`FULG_GCTRL_TEST];
            end
            if (wr_addr == `FULG_IRQ_MASK) begin
                irq_mask <= hwdata[UNITS-1:0];
            end
        end
    end

    // sticky alarms, write one to clear; a new alarm beats the clear
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_stat <= '0;
        end else if (wr_pend && wr_addr == `FULG_IRQ_STAT) begin
            irq_stat <= (irq_stat & ~hwdata[UNITS-1:0]) | alarm_evt;
        end else begin
            irq_stat <= irq_stat | alarm_evt;
        end
    end

    // level interrupt while an unmasked alarm is pending
    assign irq = |(irq_stat & irq_mask);

    // per-unit configuration and state, read by the bus mux
    logic en [UNITS];
    logic [1:0] var_cfg [UNITS];
    logic [2:0] core_cfg [UNITS];
    logic [95:0] ser_cfg [UNITS];
    logic [DATA_W-1:0] fsafe [UNITS];
    fulg_state_e state [UNITS];
    logic [1:0] rvar [UNITS];
    logic [2:0] rcore [UNITS];

    for (genvar u = 0; u < UNITS; u++) begin : g_unit
        logic hit;
        logic [4:0] off;
        logic id_ok;
        logic admit;
        fulg_state_e next_state;
        assign hit = wr_pend && unit_of(wr_addr) == 7'(u);
        assign off = wr_addr[4:0];

        // settings written by software
        // reset disabled
        always_ff @(posedge core_clk or posedge sys_rst) begin
            if (sys_rst) begin
                en[u] <= `FULG_EN_RST;
                var_cfg[u] <= `FULG_VAR_RST;
                core_cfg[u] <= `FULG_CORE_RST;
                ser_cfg[u] <= `FULG_SER_RST;
                fsafe[u] <= '0;
            end else if (hit) begin
                case (off)
                    `FULG_CFG: begin
                        en[u] <= hwdata[`FULG_CFG_EN];
                        var_cfg[u] <= hwdata[`FULG_CFG_VAR_LSB +: 2];
                        if (hwdata[`FULG_CFG_CORE_LSB +: 3] >= `FULG_CORE_MIN
                            && hwdata[`FULG_CFG_CORE_LSB +: 3]
                            <= `FULG_CORE_MAX) begin
                            core_cfg[u] <= hwdata[`FULG_CFG_CORE_LSB +: 3];
                        end
                    end
                    `FULG_SER0: ser_cfg[u][31:0] <= hwdata;
                    `FULG_SER1: ser_cfg[u][63:32] <= hwdata;
                    `FULG_SER2: ser_cfg[u][95:64] <= hwdata;
                    `FULG_FSAFE: fsafe[u] <= hwdata[DATA_W-1:0];
                    // status and unknown offsets ignore writes
                    default: begin
                    end
                endcase
            end
        end

        // identity check; variant always binds, test mode waives others
        // variant must match
        assign id_ok = rpt[u].variant == var_cfg[u]
            && (test_mode || (rpt[u].serial == ser_cfg[u]
            && rpt[u].core == core_cfg[u]));

        // state decision, rechecked on each report
        // per-report check
        always_comb begin
            next_state = state[u];
            if (!en[u]) begin
                next_state = st_disabled;
            end else if (!link_up[u]) begin
                next_state = st_comm_lost;
            end else if (rpt[u].valid) begin
                if (!id_ok) begin
                    next_state = st_mismatch;
                end else if (rpt[u].trouble) begin
                    next_state = st_trouble;
                end else begin
                    next_state = st_ok;
                end
            end else if (state[u] == st_disabled
                || state[u] == st_comm_lost) begin
                // no identity seen yet on this link: stay blocked
                next_state = st_comm_lost;
            end
        end

        // state and last reported identity
        always_ff @(posedge core_clk or posedge sys_rst) begin
            if (sys_rst) begin
                state[u] <= st_disabled;
                rvar[u] <= 2'h0;
                rcore[u] <= 3'h0;
            end else begin
                state[u] <= next_state;
                if (rpt[u].valid) begin
                    rvar[u] <= rpt[u].variant;
                    rcore[u] <= rpt[u].core;
                end
            end
        end

        // alarm event on entering mismatch; disabled units never alarm
        // mismatch alarm
        assign alarm_evt[u] = en[u] && next_state == st_mismatch
            && state[u] != st_mismatch;

        // traffic passes in ok and trouble, blocked otherwise
        // identity gate
        assign admit = next_state == st_ok || next_state == st_trouble;

        // gated data and commands, registered
        // block both ways
        always_ff @(posedge core_clk or posedge sys_rst) begin
            if (sys_rst) begin
                data_out[u] <= '0;
                cmd_out[u] <= '0;
                online[u] <= 1'b0;
            end else begin
                data_out[u] <= admit ? rx_data[u] : fsafe[u];
                cmd_out[u] <= admit ? cmd_req[u] : '0;
                online[u] <= next_state == st_ok;
            end
        end

        // bank interpretation from the configured variant
        // variant sets banks
        always_ff @(posedge core_clk or posedge sys_rst) begin
            if (sys_rst) begin
                banks[u] <= '{bank_cur_5a, bank_cur_5a};
            end else begin
                case (var_cfg[u])
                    `FULG_VAR_CC5: banks[u] <= '{bank_cur_5a, bank_cur_5a};
                    `FULG_VAR_CV5: banks[u] <= '{bank_cur_5a, bank_volt};
                    `FULG_VAR_CC1: banks[u] <= '{bank_cur_1a, bank_cur_1a};
                    `FULG_VAR_CV1: banks[u] <= '{bank_cur_1a, bank_volt};
                    default: banks[u] <= '{bank_cur_5a, bank_cur_5a};
                endcase
            end
        end
    end

    // read mux; unmapped addresses read zero
    logic [31:0] next_rdata;
    always_comb begin
        logic [6:0] ui;
        next_rdata = 32'h0;
        ui = unit_of(haddr[11:0]);
        case (haddr[11:0])
            `FULG_GCTRL: next_rdata[`FULG_GCTRL_TEST] = test_mode;
            `FULG_IRQ_STAT: next_rdata[UNITS-1:0] = irq_stat;
            `FULG_IRQ_MASK: next_rdata[UNITS-1:0] = irq_mask;
            default: begin
            end
        endcase
        for (int u = 0; u < UNITS; u++) begin
            if (ui == 7'(u)) begin
                case (haddr[4:0])
                    `FULG_CFG: next_rdata = {26'h0, core_cfg[u],
                        var_cfg[u], en[u]};
                    `FULG_SER0: next_rdata = ser_cfg[u][31:0];
                    `FULG_SER1: next_rdata = ser_cfg[u][63:32];
                    `FULG_SER2: next_rdata = ser_cfg[u][95:64];
                    `FULG_FSAFE: next_rdata = 32'(fsafe[u]);
                    `FULG_STAT: next_rdata = {label_of(u), 7'h0,
                        rcore[u], rvar[u], state[u] == st_ok, state[u]};
                    default: next_rdata = 32'h0;
                endcase
            end
        end
    end

    // read data latched at the address phase, shown in the data phase
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            hrdata <= 32'h0;
        end else if (addr_phase && !hwrite) begin
            hrdata <= next_rdata;
        end
    end

endmodule : fulg_top

// [bench/fulg_top_chk.sv]
// port checker for the link guard
`timescale 1ns/1ps
module fulg_top_chk
    import fulg_pkg::*;
#(
    parameter int CARDS = 2,
    parameter int PORTS = 8,
    parameter int DATA_W = 16,
    parameter int CMD_W = 8
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // bus and interrupt
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic irq,
    // per-unit link
    input wire fulg_rpt_s rpt [CARDS*PORTS],
    input wire logic link_up [CARDS*PORTS],
    input wire logic [DATA_W-1:0] rx_data [CARDS*PORTS],
    input wire logic [CMD_W-1:0] cmd_out [CARDS*PORTS],
    input wire logic [CMD_W-1:0] cmd_req [CARDS*PORTS],
    input wire logic [DATA_W-1:0] data_out [CARDS*PORTS],
    input wire logic online [CARDS*PORTS],
    input wire fulg_banks_s banks [CARDS*PORTS]
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    logic any_v; // some unit reported
    logic [1:0] v0; // variant implied by unit 0 banks
    // any report this cycle
    always_comb begin
        any_v = 1'b0;
        for (int u = 0; u < CARDS*PORTS; u++) any_v |= rpt[u].valid;
    end
    assign v0 = {banks[0].bank0 == bank_cur_1a, banks[0].bank1 == bank_volt};
    property p_pass;
        online[0] |-> data_out[0] == $past(rx_data[0])
            && cmd_out[0] == $past(cmd_req[0]);
    endproperty
    a_pass: assert property (p_pass) else $error("unit 0 blocks");
    property p_far;
        online[15] |-> data_out[15] == $past(rx_data[15]);
    endproperty
    a_far: assert property (p_far) else $error("unit 15 blocks");
    property p_lost;
        !$past(link_up[0]) |-> !online[0] && cmd_out[0] == '0;
    endproperty
    a_lost: assert property (p_lost) else $error("lost link");
    property p_var;
        $past(rpt[0].valid && link_up[0] && rpt[0].variant != v0)
            |-> !online[0] && cmd_out[0] == '0;
    endproperty
    a_var: assert property (p_var) else $error("variant slip");
    property p_trb;
        $past(rpt[0].valid && rpt[0].trouble) |-> !online[0];
    endproperty
    a_trb: assert property (p_trb) else $error("online in trouble");
    property p_hold;
        (!hsel)[*4] ##0 online[0] && link_up[0] && !rpt[0].valid
            |=> online[0];
    endproperty
    a_hold: assert property (p_hold) else $error("state lost");
    property p_banks;
        banks[0].bank0 != bank_volt && (banks[0].bank1 == bank_volt
            || banks[0].bank1 == banks[0].bank0);
    endproperty
    a_banks: assert property (p_banks) else $error("bank code");
    property p_irq;
        $rose(irq) |-> $past(any_v) || $past(hsel && htrans[1], 2);
    endproperty
    a_irq: assert property (p_irq) else $error("irq without cause");
    c_ok: cover property ($rose(online[0]));
    c_far: cover property ($rose(online[15]));
    c_irq: cover property ($rose(irq));
endmodule : fulg_top_chk

bind fulg_top fulg_top_chk #(.CARDS(CARDS), .PORTS(PORTS), .DATA_W(DATA_W),
    .CMD_W(CMD_W)) i_chk (.core_clk(core_clk), .sys_rst(sys_rst),
    .hsel(hsel), .htrans(htrans), .irq(irq), .rpt(rpt), .link_up(link_up),
    .rx_data(rx_data), .cmd_out(cmd_out), .cmd_req(cmd_req),
    .data_out(data_out), .online(online), .banks(banks));

// [bench/fulg_remote.sv]
// remote unit model on one guard port
`timescale 1ns/1ps
module fulg_remote
    import fulg_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // bench control
    input wire logic go,
    input wire logic [3:0] lag,
    input wire fulg_rpt_s id,
    input wire logic plug,
    // link side
    output fulg_rpt_s rpt,
    output logic link_up,
    output logic [15:0] rx_data
);
    logic [4:0] n; // cycles left until the report
    // report timer; samples change every cycle so stale data shows
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            n <= 5'h0;
            rx_data <= 16'h0;
        end else begin
            rx_data <= rx_data * 16'h5 + 16'h3b;
            n <= go ? {1'b0, lag} + 5'h1 : n - {4'h0, n != 5'h0};
        end
    end
    // identity only valid while reporting, garbage otherwise
    always_comb begin
        rpt = (n == 5'h1) ? id : ~id;
        rpt.valid = (n == 5'h1);
    end
    assign link_up = plug;
endmodule : fulg_remote

// [bench/fulg_top_bench.sv]
// self-checking bench of the link guard
`timescale 1ns/1ps
`include "fulg_regs.svh"
module fulg_top_bench
    import fulg_pkg::*;
;
    typedef struct packed {
        logic en, tst;
        logic [1:0] v;
        logic tr, sb, cb, vb;
        fulg_state_e st;
    } fulg_row_s;
    // enable, test, variant, trouble, bad serial/core/variant, state
    localparam fulg_row_s ROWS [9] = '{'{0,0,0,0,0,0,0,st_disabled},
        '{1,0,0,0,0,0,0,st_ok}, '{1,0,1,0,1,0,0,st_mismatch},
        '{1,0,2,0,0,1,0,st_mismatch}, '{1,0,3,0,0,0,1,st_mismatch},
        '{1,1,1,0,1,0,0,st_ok}, '{1,1,2,0,0,1,0,st_ok},
        '{1,1,3,0,0,0,1,st_mismatch}, '{1,0,0,1,0,0,0,st_trouble}};
    localparam fulg_banks_s BK [4] = '{'{bank_cur_5a, bank_cur_5a},
        '{bank_cur_5a, bank_volt}, '{bank_cur_1a, bank_cur_1a},
        '{bank_cur_1a, bank_volt}};
    localparam logic [95:0] SER = 96'h4142_4344_4546_4748_494a_4b4c;
    localparam logic [15:0] FS = 16'h5a5a; // failsafe of unit 0
    logic core_clk, sys_rst, hsel, hwrite, hreadyout, hresp, irq;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [3:0] lag;
    fulg_rpt_s rpt [16], id [16];
    logic link_up [16], plug [16], go [16], online [16];
    logic [15:0] rx_data [16], data_out [16], prx;
    logic [7:0] cmd_req [16], cmd_out [16], pcm;
    fulg_banks_s banks [16];
    int num_errors = 0, samples_checked = 0, cyc = 0;
    fulg_top i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .irq(irq), .rpt(rpt),
        .link_up(link_up), .rx_data(rx_data), .cmd_out(cmd_out),
        .cmd_req(cmd_req), .data_out(data_out), .online(online),
        .banks(banks));
    for (genvar u = 0; u < 16; u++) begin : g_rem
        fulg_remote i_rem (.core_clk(core_clk), .sys_rst(sys_rst),
            .go(go[u]), .lag(lag), .id(id[u]), .plug(plug[u]),
            .rpt(rpt[u]), .link_up(link_up[u]), .rx_data(rx_data[u]));
    end
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    // last sampled inputs of unit 0, moving commands, hang guard
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        prx <= rx_data[0];
        pcm <= cmd_req[0];
        for (int u = 0; u < 16; u++) cmd_req[u] <= cmd_req[u] + 8'(u + 1);
        if (cyc == 5000) begin
            $display("mismatch at %0t: timeout", $time);
            num_errors++;
            stop_test();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    // one single word transfer, read data left in q
    task automatic ahb(input logic [11:0] a, input logic w,
        input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        q = hrdata;
        chk({31'h0, hresp}, 32'h0);
    endtask : ahb
    // one status report after a lag; returns at the settled half cycle
    task automatic report(input int u, input int gap);
        lag <= 4'(gap);
        go[u] <= 1'b1;
        @(posedge core_clk);
        go[u] <= 1'b0;
        @(negedge core_clk);
        while (rpt[u].valid !== 1'b1) @(negedge core_clk);
        @(negedge core_clk);
    endtask : report
    task automatic look(input logic on, input logic adm);
        chk({31'h0, online[0]}, {31'h0, on});
        chk({16'h0, data_out[0]}, {16'h0, adm ? prx : FS});
        chk({24'h0, cmd_out[0]}, {24'h0, adm ? pcm : 8'h0});
        @(posedge core_clk);
    endtask : look
    task automatic irq_is(input logic e);
        @(negedge core_clk);
        chk({31'h0, irq}, {31'h0, e});
        @(posedge core_clk);
    endtask : irq_is
    task stop_test;
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : stop_test
    initial begin
        fulg_row_s r;
        sys_rst = 1'b1;
        {hsel, hwrite, htrans, haddr, hwdata, lag} = '0;
        hsize = 3'h2;
        for (int u = 0; u < 16; u++) begin
            {go[u], plug[u], cmd_req[u]} = {2'b01, 8'(u)};
            id[u] = {1'b0, (u == 15) ? 96'h0 : SER, 2'h0, 3'h1, 1'b0};
        end
        repeat (8) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        for (int i = 0; i < 3; i++) begin
            ahb(12'h104 + 12'(4*i), 1, SER[32*i +: 32]);
        end
        ahb(12'h110, 1, {16'h0, FS});
        // table of identity cases on unit 0
        foreach (ROWS[i]) begin
            r = ROWS[i];
            ahb(`FULG_GCTRL, 1, {31'h0, r.tst});
            ahb(12'h100, 1, {26'h0, 3'h1, r.v, r.en});
            id[0] <= {1'b0, SER ^ 96'(r.sb), r.v ^ {1'b0, r.vb},
                r.cb ? 3'h3 : 3'h1, r.tr};
            report(0, i % 3);
            chk({28'h0, banks[0]}, {28'h0, BK[r.v]});
            look(r.st == st_ok, r.st inside {st_ok, st_trouble});
            ahb(12'h114, 0, 0);
            chk({29'h0, q[2:0]}, {29'h0, r.st});
        end
        // sticky event, masked, then cleared
        ahb(`FULG_IRQ_STAT, 0, 0);
        chk(q, 32'h1);
        irq_is(1'b0);
        ahb(`FULG_IRQ_MASK, 1, 32'h1);
        irq_is(1'b1);
        ahb(`FULG_IRQ_STAT, 1, 32'h1);
        irq_is(1'b0);
        // link loss in mid-run
        plug[0] <= 1'b0;
        @(posedge core_clk);
        @(negedge core_clk);
        look(1'b0, 1'b0);
        ahb(12'h114, 0, 0);
        chk({29'h0, q[2:0]}, 32'h1);
        plug[0] <= 1'b1;
        // core five refused, old core one kept
        ahb(12'h100, 1, 32'h29);
        ahb(12'h100, 0, 0);
        chk(q, 32'h9);
        id[0] <= {1'b0, SER, 2'h0, 3'h1, 1'b0};
        report(0, 5);
        look(1'b1, 1'b1);
        // software mutes unit 0; a bad unit then raises nothing
        ahb(12'h100, 1, 32'h8);
        id[0].serial <= 96'h0;
        report(0, 0);
        look(1'b0, 1'b0);
        ahb(`FULG_IRQ_STAT, 0, 0);
        chk(q, 32'h0);
        // last unit of second card on its own port
        ahb(12'h2f4, 0, 0);
        chk(q, {`FULG_SLOT1, `FULG_DIGIT0 + 8'h8, 16'h0});
        ahb(12'h2e0, 1, 32'h9);
        report(15, 2);
        chk({30'h0, online[15], online[0]}, 32'h2);
        @(posedge core_clk);
        ahb(12'h0fc, 0, 0);
        chk(q, 32'h0);
        ahb(12'h114, 1, 32'hffff_ffff);
        ahb(12'h114, 0, 0);
        chk({29'h0, q[2:0]}, 32'h0);
        // second reset returns the unit to disabled
        sys_rst <= 1'b1;
        repeat (8) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        ahb(12'h2e0, 0, 0);
        chk(q, 32'h8);
        stop_test();
    end
endmodule : fulg_top_bench
